// [hw/charge_detect_mask_and_hub_power_cfg.sv]
// Hub charge-detect mask and portable hub power configuration, AHB-Lite slave
`timescale 1ns/1ps
module charge_detect_mask_and_hub_power_cfg
   import hub_power_cfg_pkg::*;
#(
   parameter int PHY_PORTS = 5,
   parameter int SEL_PORTS = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [15:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Hub session and charger detector conditions
   input wire hub_cond_s hub_cond,
   input wire logic detect_active,
   input wire logic [SEL_PORTS-1:0] port_power_req,
   // Outputs to the rest of the hub
   output logic composite_charge_detect,
   output logic suspend_clock_gate,
   output logic [PHY_PORTS:1] phy_clock_disable,
   output logic port_power_pin_a,
   output logic reverse_data_source,
   output logic irq
);

   // Register storage
   logic [7:0] charge_detect_mask;
   logic [7:0] portable_hub_config;
   logic [7:0] port_select_low_power;
   logic [7:0] detect_control;
   logic [IRQ_COUNT-1:0] irq_status;
   logic [IRQ_COUNT-1:0] irq_enable;

   // Bus pipeline
   ahb_req_s req;
   logic addr_valid;
   logic dp_write;
   logic dp_read;
   logic [15:0] dp_addr;
   logic read_wait;
   logic wr_en;
   logic [7:0] wr_byte;
   logic [31:0] next_rdata;

   // Event detection
   logic composite_q;
   logic chargers_q;
   logic chargers_now;
   logic [IRQ_COUNT-1:0] irq_event;
   logic [IRQ_COUNT-1:0] irq_clear;

   logic [1:0] port_sel;

   // Gather the request into one carrier
   assign req.hsel = hsel;
   assign req.haddr = haddr;
   assign req.htrans = htrans;
   assign req.hwrite = hwrite;
   assign req.hsize = hsize;
   assign req.hready = hready;

   // Only NONSEQ single transfers exist on this bus
   assign addr_valid = req.hsel && req.hready && (req.htrans == HTRANS_NONSEQ);

   // Address phase capture
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 16'h0000;
      end else if (hready) begin
         dp_write <= addr_valid && req.hwrite;
         dp_read <= addr_valid && !req.hwrite;
         dp_addr <= req.haddr;
      end
   end

   // Reads take one wait state so write data of the prior beat is visible
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         read_wait <= 1'b0;
      end else if (dp_read && !read_wait) begin
         read_wait <= 1'b1;
      end else begin
         read_wait <= 1'b0;
      end
   end

   assign hreadyout = !(dp_read && !read_wait);
   assign hresp = HRESP_OKAY;

   // Writes land in the data phase; only the low byte carries data
   assign wr_en = dp_write;
   assign wr_byte = hwdata[7:0];

   // mask register
   // Session and charger masks are plain read/write bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         charge_detect_mask <= CHARGE_DETECT_MASK_RST;
      end else if (wr_en && dp_addr == 16'(CHARGE_DETECT_MASK_IDX * 4)) begin
         charge_detect_mask <= wr_byte;
      end
   end

   // reserved bits held zero
   // Portable hub register keeps only the keep-clock and PHY disable bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         portable_hub_config <= PORTABLE_HUB_CONFIG_RST;
      end else if (wr_en && dp_addr == 16'(PORTABLE_HUB_CONFIG_IDX * 4)) begin
         portable_hub_config <= wr_byte & PORTABLE_HUB_CONFIG_WMASK;
      end
   end

   // software programs early
   // Written at any time; changing it mid-traffic is the software's hazard
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_select_low_power <= PORT_SELECT_LOW_POWER_RST;
      end else if (wr_en && dp_addr == 16'(PORT_SELECT_LOW_POWER_IDX * 4)) begin
         port_select_low_power <= wr_byte & PORT_SELECT_LOW_POWER_WMASK;
      end
   end

   // Detector control, holds the enhanced detect enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         detect_control <= DETECT_CONTROL_RST;
      end else if (wr_en && dp_addr == 16'(DETECT_CONTROL_IDX * 4)) begin
         detect_control <= wr_byte & DETECT_CONTROL_WMASK;
      end
   end

   // Interrupt enable register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= IRQ_ENABLE_RST;
      end else if (wr_en && dp_addr == 16'(IRQ_ENABLE_IDX * 4)) begin
         irq_enable <= wr_byte[IRQ_COUNT-1:0];
      end
   end

   // Write-only clear strobe; reads of that address give zero
   always_comb begin
      irq_clear = '0;
      if (wr_en && dp_addr == 16'(IRQ_CLEAR_IDX * 4)) begin
         irq_clear = wr_byte[IRQ_COUNT-1:0];
      end
   end

   charge_detect_combiner #(
      .COND_W(8)
   ) u_combiner (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cond(hub_cond),
      .mask(charge_detect_mask),
      .composite(composite_charge_detect)
   );

   // software pairs bit 1 with enhanced detect
   // The charging port condition is passed as given; without enhanced
   // detection the detector simply never reports it
   assign chargers_now = hub_cond.super_high_charger | hub_cond.high_charger | hub_cond.low_charger
                       | hub_cond.charging_port | hub_cond.dedicated_port;

   // Previous values for edge events
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         composite_q <= 1'b0;
         chargers_q <= 1'b0;
      end else begin
         composite_q <= composite_charge_detect;
         chargers_q <= chargers_now;
      end
   end

   assign irq_event[IRQ_RISE_BIT] = composite_charge_detect && !composite_q;
   assign irq_event[IRQ_FALL_BIT] = !composite_charge_detect && composite_q;
   assign irq_event[IRQ_CHARGER_BIT] = chargers_now && !chargers_q;

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   // Level interrupt while any enabled status bit stands
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // suspend clock gating
   // Keep-clock costs suspend current but keeps the config port alive
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         suspend_clock_gate <= 1'b0;
      end else begin
         suspend_clock_gate <= hub_cond.suspended && !portable_hub_config[KEEP_CLOCK_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phy_clock_disable <= '0;
      end else begin
         phy_clock_disable <= portable_hub_config[PHY_CLK_DIS_MSB:PHY_CLK_DIS_LSB];
      end
   end

   // power pin port mapping
   // Code 0 is port 1, so the code indexes the zero-based request vector
   assign port_sel = port_select_low_power[PORT_SEL_MSB:PORT_SEL_LSB];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_power_pin_a <= 1'b0;
      end else begin
         port_power_pin_a <= port_power_req[port_sel];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reverse_data_source <= 1'b0;
      end else begin
         reverse_data_source <= detect_active && detect_control[ENHANCED_DETECT_BIT];
      end
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (dp_addr == 16'(CHARGE_DETECT_MASK_IDX * 4)) begin
         next_rdata[7:0] = charge_detect_mask;
      end else if (dp_addr == 16'(PORTABLE_HUB_CONFIG_IDX * 4)) begin
         next_rdata[7:0] = portable_hub_config;
      end else if (dp_addr == 16'(PORT_SELECT_LOW_POWER_IDX * 4)) begin
         next_rdata[7:0] = port_select_low_power;
      end else if (dp_addr == 16'(DETECT_CONTROL_IDX * 4)) begin
         next_rdata[7:0] = detect_control;
      end else if (dp_addr == 16'(HUB_STATE_IDX * 4)) begin
         next_rdata[7:0] = hub_cond;
         next_rdata[8] = composite_charge_detect;
      end else if (dp_addr == 16'(IRQ_STATUS_IDX * 4)) begin
         next_rdata[IRQ_COUNT-1:0] = irq_status;
      end else if (dp_addr == 16'(IRQ_ENABLE_IDX * 4)) begin
         next_rdata[IRQ_COUNT-1:0] = irq_enable;
      end
   end

   // Read data loaded in the wait cycle, held until the next read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (dp_read && !read_wait) begin
         hrdata <= next_rdata;
      end
   end

endmodule

// [hw/hub_power_cfg_pkg.sv]
// Constants, register map and carrier types for the hub charge-detect and power config block
package hub_power_cfg_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [15:0] CHARGE_DETECT_MASK_IDX = 16'h30ED;
   localparam logic [15:0] PORTABLE_HUB_CONFIG_IDX = 16'h30EE;
   localparam logic [15:0] PORT_SELECT_LOW_POWER_IDX = 16'h318B;
   localparam logic [15:0] DETECT_CONTROL_IDX = 16'h3190;
   localparam logic [15:0] HUB_STATE_IDX = 16'h3191;
   localparam logic [15:0] IRQ_STATUS_IDX = 16'h3192;
   localparam logic [15:0] IRQ_CLEAR_IDX = 16'h3193;
   localparam logic [15:0] IRQ_ENABLE_IDX = 16'h3194;

   // Reset values
   localparam logic [7:0] CHARGE_DETECT_MASK_RST = 8'h1F;
   localparam logic [7:0] PORTABLE_HUB_CONFIG_RST = 8'h10;
   localparam logic [7:0] PORT_SELECT_LOW_POWER_RST = 8'h00;
   localparam logic [7:0] DETECT_CONTROL_RST = 8'h00;
   localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

   // Writable bits; the rest are reserved and read zero
   localparam logic [7:0] PORTABLE_HUB_CONFIG_WMASK = 8'hBE;
   localparam logic [7:0] PORT_SELECT_LOW_POWER_WMASK = 8'hC0;
   localparam logic [7:0] DETECT_CONTROL_WMASK = 8'h01;

   // Field positions
   localparam int KEEP_CLOCK_BIT = 7;
   localparam int PHY_CLK_DIS_LSB = 1;
   localparam int PHY_CLK_DIS_MSB = 5;
   localparam int PORT_SEL_LSB = 6;
   localparam int PORT_SEL_MSB = 7;
   localparam int ENHANCED_DETECT_BIT = 0;

   // Interrupt event bits
   localparam int IRQ_RISE_BIT = 0;
   localparam int IRQ_FALL_BIT = 1;
   localparam int IRQ_CHARGER_BIT = 2;
   localparam int IRQ_COUNT = 3;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Hub session and charger conditions, bit order equals the mask layout
   typedef struct packed {
      logic configured;
      logic connected;
      logic suspended;
      logic super_high_charger;
      logic high_charger;
      logic low_charger;
      logic charging_port;
      logic dedicated_port;
   } hub_cond_s;

   // AHB-Lite request from the master side
   typedef struct packed {
      logic hsel;
      logic [15:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } ahb_req_s;

endpackage

// [hw/charge_detect_combiner.sv]
// Masked OR of hub conditions into the composite charge-detect status
`timescale 1ns/1ps
module charge_detect_combiner
   import hub_power_cfg_pkg::*;
#(
   parameter int COND_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [COND_W-1:0] cond,
   input wire logic [COND_W-1:0] mask,
   output logic composite
);

   logic [COND_W-1:0] hit;

   // per-bit gating
   // Each condition passes only where its mask bit is set
   genvar i;
   generate
      for (i = 0; i < COND_W; i++) begin : g_gate
         assign hit[i] = cond[i] & mask[i];
      end
   endgenerate

   // registered OR
   // Registered so the status pin never glitches on mask writes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         composite <= 1'b0;
      end else begin
         composite <= |hit;
      end
   end

endmodule

// [verif/hub_power_cfg_asserts.sv]
// Port-level checker for the hub charge-detect and power config block
`timescale 1ns/1ps
module hub_power_cfg_asserts
   import hub_power_cfg_pkg::*;
#(
   parameter int PHY_PORTS = 5,
   parameter int SEL_PORTS = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [15:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire hub_cond_s hub_cond,
   input wire logic detect_active,
   input wire logic [SEL_PORTS-1:0] port_power_req,
   input wire logic composite_charge_detect,
   input wire logic suspend_clock_gate,
   input wire logic [PHY_PORTS:1] phy_clock_disable,
   input wire logic port_power_pin_a,
   input wire logic reverse_data_source,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Accepted transfer in this cycle
   logic taken;
   assign taken = hsel && hready && (htrans == HTRANS_NONSEQ);

   // No condition seen means nothing to report, whatever the mask
   property p_comp_idle; ($past(hub_cond) == 8'h00) |-> !composite_charge_detect; endproperty
   a_comp_idle: assert property (p_comp_idle) else $error("composite high with no condition");
   // Gating only while suspended
   property p_gate; suspend_clock_gate |-> $past(hub_cond.suspended); endproperty
   a_gate: assert property (p_gate) else $error("clock gate without suspend");
   property p_reverse; reverse_data_source |-> $past(detect_active); endproperty
   a_reverse: assert property (p_reverse) else $error("source reversed with detection idle");
   // Pin follows one of the requests, never invents power
   property p_pin; port_power_pin_a |-> $past(port_power_req) != '0; endproperty
   a_pin: assert property (p_pin) else $error("power pin high with no request");
   property p_okay; hresp == HRESP_OKAY; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   // Read costs exactly one wait state
   property p_rd_wait; (taken && !hwrite) |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_nowait; (taken && hwrite) |=> hreadyout; endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_low_once; !hreadyout |=> hreadyout; endproperty
   a_low_once: assert property (p_low_once) else $error("ready low too long");
endmodule

bind charge_detect_mask_and_hub_power_cfg hub_power_cfg_asserts #(.PHY_PORTS(PHY_PORTS), .SEL_PORTS(SEL_PORTS))
   i_asserts (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .hub_cond(hub_cond), .detect_active(detect_active), .port_power_req(port_power_req),
   .composite_charge_detect(composite_charge_detect), .suspend_clock_gate(suspend_clock_gate),
   .phy_clock_disable(phy_clock_disable), .port_power_pin_a(port_power_pin_a),
   .reverse_data_source(reverse_data_source), .irq(irq));

// [verif/testbench.sv]
// Register-level testbench for the hub charge-detect and power config block
`timescale 1ns/1ps
module testbench
   import hub_power_cfg_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n, hsel, hwrite, hreadyout, hresp, detect_active;
   logic [15:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [3:0] port_power_req;
   hub_cond_s hub_cond;
   logic composite_charge_detect, suspend_clock_gate, port_power_pin_a, reverse_data_source, irq;
   logic [5:1] phy_clock_disable;
   wire logic hready;
   int mismatches = 0;
   int n_tests = 0;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   always #10 ref_clk = ~ref_clk;

   charge_detect_mask_and_hub_power_cfg i_charge_detect_mask_and_hub_power_cfg (.ref_clk(ref_clk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .hub_cond(hub_cond), .detect_active(detect_active), .port_power_req(port_power_req),
      .composite_charge_detect(composite_charge_detect), .suspend_clock_gate(suspend_clock_gate),
      .phy_clock_disable(phy_clock_disable), .port_power_pin_a(port_power_pin_a),
      .reverse_data_source(reverse_data_source), .irq(irq));

   task automatic wrap_up;
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic ck(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask

   // Mid-cycle look equals what the next edge samples; bounded so a hang ends the run
   task automatic wait_rdy;
      int k;
      k = 0;
      @(negedge ref_clk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 20) begin
            mismatches++;
            wrap_up();
         end
         @(negedge ref_clk);
      end
      rd = hrdata;
      @(posedge ref_clk);
   endtask

   // One single-word transfer: address phase, then data phase
   task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {idx[13:0], 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rdck(input logic [15:0] idx, input logic [31:0] e);
      acc(1'b0, idx, 32'h0);
      ck(rd, e);
   endtask

   // Outputs lag a register write or input change by up to three edges; margin added
   task automatic st;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   initial begin
      {hsel, hwrite, detect_active, rst_n} = 4'h0;
      haddr = 16'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      port_power_req = 4'h0;
      hub_cond = hub_cond_s'(8'h00);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdck(CHARGE_DETECT_MASK_IDX, 32'h1F);
      rdck(PORTABLE_HUB_CONFIG_IDX, 32'h10);
      rdck(PORT_SELECT_LOW_POWER_IDX, 32'h0);
      acc(1'b1, PORTABLE_HUB_CONFIG_IDX, 32'hFF);
      rdck(PORTABLE_HUB_CONFIG_IDX, 32'hBE);
      @(posedge ref_clk) hub_cond <= hub_cond_s'(8'h20);
      st();
      ck(32'(phy_clock_disable), 32'h1F);
      ck(32'(suspend_clock_gate), 32'h0);
      acc(1'b1, PORTABLE_HUB_CONFIG_IDX, 32'h04);
      st();
      ck(32'(phy_clock_disable), 32'h02);
      ck(32'(suspend_clock_gate), 32'h1);
      // Unmapped place reads zero and swallows writes
      acc(1'b1, 16'h0100, 32'hFF);
      rdck(16'h0100, 32'h0);
      @(posedge ref_clk) detect_active <= 1'b1;
      st();
      ck(32'(reverse_data_source), 32'h0);
      // enhanced detect on before charging port mask
      acc(1'b1, DETECT_CONTROL_IDX, 32'h1);
      st();
      ck(32'(reverse_data_source), 32'h1);
      rdck(DETECT_CONTROL_IDX, 32'h1);
      // Each mask bit alone against its own condition and all others
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, CHARGE_DETECT_MASK_IDX, 32'(8'h01 << i));
         @(posedge ref_clk) hub_cond <= hub_cond_s'(8'h01 << i);
         st();
         ck(32'(composite_charge_detect), 32'h1);
         @(posedge ref_clk) hub_cond <= hub_cond_s'(~(8'h01 << i));
         st();
         ck(32'(composite_charge_detect), 32'h0);
      end
      // Every port code, selected request high then low with others high
      for (int c = 0; c < 4; c++) begin
         // select changed only while no port traffic
         @(posedge ref_clk) port_power_req <= 4'h0;
         acc(1'b1, PORT_SELECT_LOW_POWER_IDX, 32'(c) << 6);
         @(posedge ref_clk) port_power_req <= 4'h1 << c;
         st();
         ck(32'(port_power_pin_a), 32'h1);
         @(posedge ref_clk) port_power_req <= ~(4'h1 << c);
         st();
         ck(32'(port_power_pin_a), 32'h0);
      end
      acc(1'b1, PORT_SELECT_LOW_POWER_IDX, 32'hFF);
      rdck(PORT_SELECT_LOW_POWER_IDX, 32'hC0);
      // Interrupt raised, masked, unmasked, cleared
      @(posedge ref_clk) hub_cond <= hub_cond_s'(8'h00);
      acc(1'b1, CHARGE_DETECT_MASK_IDX, 32'h01);
      acc(1'b1, IRQ_CLEAR_IDX, 32'h07);
      acc(1'b1, IRQ_ENABLE_IDX, 32'h01);
      @(posedge ref_clk) hub_cond <= hub_cond_s'(8'h01);
      st();
      ck(32'(irq), 32'h1);
      acc(1'b1, IRQ_ENABLE_IDX, 32'h0);
      st();
      ck(32'(irq), 32'h0);
      acc(1'b1, IRQ_ENABLE_IDX, 32'h01);
      st();
      ck(32'(irq), 32'h1);
      // Composite rise and charger rise both latched
      rdck(IRQ_STATUS_IDX, 32'h5);
      rdck(HUB_STATE_IDX, 32'h101);
      acc(1'b1, IRQ_CLEAR_IDX, 32'h07);
      st();
      ck(32'(irq), 32'h0);
      rdck(IRQ_STATUS_IDX, 32'h0);
      rdck(IRQ_CLEAR_IDX, 32'h0);
      // Composite fall latched, but its bit is not enabled
      @(posedge ref_clk) hub_cond <= hub_cond_s'(8'h00);
      st();
      ck(32'(irq), 32'h0);
      rdck(IRQ_STATUS_IDX, 32'h2);
      wrap_up();
   end
endmodule
